/* File: rtl/vim_pkg.sv */
// shared constants for the vectored interrupt manager
package vim_pkg;

  // channel space
  localparam int          VIM_NCH        = 128;
  localparam int          VIM_IDX_W      = 7;
  localparam int          VIM_VEC_W      = 32;
  localparam int          VIM_LAST_USE   = 126;  // last channel with a table slot
  localparam logic [6:0]  VIM_PHANTOM    = 7'h00;  // table slot of the phantom handler

  // reset values
  localparam logic [127:0] VIM_EN_RST    = 128'h1;  // only channel 0, the high error channel, starts enabled
  localparam logic [31:0]  VIM_VEC_RST   = 32'h0;
  // channels with no source behind them; their inputs are forced inactive
  localparam logic [127:0] VIM_RSVD_MASK =
    128'hffff0000_00d0f1f8_44110a11_00040002;
  // channel 127 has no table slot and is never forwarded
  localparam logic [127:0] VIM_USE_MASK  =
    128'h7fffffff_ffffffff_ffffffff_ffffffff;

  // source numbering: each source line is numbered by its default channel
  localparam logic [6:0] SRC_ERR_HIGH    = 7'h00;
  localparam logic [6:0] SRC_ERR_LOW     = 7'h14;
  localparam logic [6:0] SRC_TICK_CMP0   = 7'h02;
  localparam logic [6:0] SRC_TICK_CMP3   = 7'h05;
  localparam logic [6:0] SRC_TICK_OVF0   = 7'h06;
  localparam logic [6:0] SRC_TICK_OVF1   = 7'h07;
  localparam logic [6:0] SRC_TICK_BASE   = 7'h08;
  localparam logic [6:0] SRC_CONV1_EVT   = 7'h0e;
  localparam logic [6:0] SRC_CONV1_G1    = 7'h0f;
  localparam logic [6:0] SRC_CONV1_G2    = 7'h1c;
  localparam logic [6:0] SRC_CONV2_EVT   = 7'h32;
  localparam logic [6:0] SRC_CONV2_G1    = 7'h33;
  localparam logic [6:0] SRC_CONV2_G2    = 7'h39;
  localparam logic [6:0] SRC_CONV1_MAG   = 7'h1f;
  localparam logic [6:0] SRC_CONV2_MAG   = 7'h3b;
  localparam logic [6:0] SRC_PT1_L0      = 7'h0a;
  localparam logic [6:0] SRC_PT1_L1      = 7'h18;
  localparam logic [6:0] SRC_TU1_L0      = 7'h0b;
  localparam logic [6:0] SRC_TU1_L1      = 7'h19;
  localparam logic [6:0] SRC_PT2_L0      = 7'h3f;
  localparam logic [6:0] SRC_PT2_L1      = 7'h49;
  localparam logic [6:0] SRC_TU2_L0      = 7'h41;
  localparam logic [6:0] SRC_TU2_L1      = 7'h4b;
  localparam logic [6:0] SRC_CAN1_L0     = 7'h10;
  localparam logic [6:0] SRC_CAN1_L1     = 7'h1d;
  localparam logic [6:0] SRC_CAN1_IF3    = 7'h2c;
  localparam logic [6:0] SRC_CAN2_L0     = 7'h23;
  localparam logic [6:0] SRC_CAN2_L1     = 7'h2a;
  localparam logic [6:0] SRC_CAN2_IF3    = 7'h2e;
  localparam logic [6:0] SRC_CAN3_L0     = 7'h2d;
  localparam logic [6:0] SRC_CAN3_L1     = 7'h37;
  localparam logic [6:0] SRC_CAN3_IF3    = 7'h3c;
  localparam logic [6:0] SRC_BSPI1_L0    = 7'h0c;
  localparam logic [6:0] SRC_BSPI1_L1    = 7'h1a;
  localparam logic [6:0] SRC_PLAIN_SPI_TWO_L0     = 7'h11;
  localparam logic [6:0] SRC_PLAIN_SPI_TWO_L1     = 7'h1e;
  localparam logic [6:0] SRC_BSPI3_L0    = 7'h25;
  localparam logic [6:0] SRC_BSPI3_L1    = 7'h26;
  localparam logic [6:0] SRC_BSPI5_L0    = 7'h35;
  localparam logic [6:0] SRC_BSPI5_L1    = 7'h38;
  localparam logic [6:0] SRC_PLAIN_SPI_FOUR_L0     = 7'h31;
  localparam logic [6:0] SRC_PLAIN_SPI_FOUR_L1     = 7'h36;
  localparam logic [6:0] SRC_SER_L0      = 7'h40;
  localparam logic [6:0] SRC_SER_L1      = 7'h4a;
  localparam logic [6:0] SRC_I2C_L0      = 7'h42;
  localparam logic [6:0] SRC_LIN_L0      = 7'h0d;
  localparam logic [6:0] SRC_LIN_L1      = 7'h1b;

endpackage

/* File: rtl/vim_prio_enc.sv */
`timescale 1ns/100ps
// fixed priority pick: the lowest set bit wins
module vim_prio_enc #(
  parameter int N  = 128,
  parameter int IW = 7
) (
  input  wire logic [N-1:0]  i_req,
  output logic               o_valid,
  output logic [IW-1:0]      o_idx
);

  if (N > (1 << IW)) begin : g_chk
    $error("vim_prio_enc: index too narrow for request count");
  end

  // scan downward so the lowest pending index is the last one written
  always_comb begin
    o_valid = 1'b0;
    o_idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_valid = 1'b1;
        o_idx   = IW'(i);
      end
    end
  end

endmodule // vim_prio_enc

/* File: rtl/vim_vec_table.sv */
`timescale 1ns/100ps
// vector table with one even-parity bit per word, synchronous read
module vim_vec_table #(
  parameter int DEPTH = 128,
  parameter int AW    = 7,
  parameter int W     = 32
) (
  input  wire logic          i_mclk,
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic          i_par_flip,
  input  wire logic [AW-1:0] i_raddr,
  output logic     [W-1:0]   o_rdata,
  output logic               o_par_err
);

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("vim_vec_table: address too narrow for depth");
  end

  logic [W:0] mem [DEPTH];   // parity kept in the top bit
  logic [W:0] rd_reg;

  // parity flip lets software plant an error to prove the checker
  always_ff @(posedge i_mclk) begin
    if (i_wr) begin
      mem[i_waddr] <= {(^i_wdata) ^ i_par_flip, i_wdata};
    end
  end

  // read every cycle; the array itself has no reset
  always_ff @(posedge i_mclk) begin
    rd_reg <= mem[i_raddr];
  end

  // checked on every read, so a flipped stored bit shows at once
  assign o_rdata   = rd_reg[W-1:0];
  assign o_par_err = (^rd_reg[W-1:0]) != rd_reg[W];

endmodule // vim_vec_table

/* File: rtl/vim_top.sv */
`timescale 1ns/100ps
module vim_top
  import vim_pkg::*;
#(
  parameter int          NCH          = VIM_NCH,
  parameter logic [31:0] FALLBACK_VEC = 32'h0  // used when a table word fails parity
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_srst,
  // peripheral request lines, numbered by default channel
  input  wire logic [NCH-1:0]       i_src_req,
  // per-channel enable programming
  input  wire logic                 i_en_wr,
  input  wire logic [VIM_IDX_W-1:0] i_en_chan,
  input  wire logic                 i_en_val,
  // per-channel source map programming
  input  wire logic                 i_map_wr,
  input  wire logic [VIM_IDX_W-1:0] i_map_chan,
  input  wire logic [VIM_IDX_W-1:0] i_map_src,
  // vector table programming
  input  wire logic                 i_vt_wr,
  input  wire logic [VIM_IDX_W-1:0] i_vt_addr,
  input  wire logic [VIM_VEC_W-1:0] i_vt_data,
  input  wire logic                 i_vt_par_flip,
  // dispatch mode and error flag clear
  input  wire logic                 i_vec_port_en,
  input  wire logic                 i_par_clr,
  // core side
  output logic                      o_core_irq,
  output logic                      o_core_vec_valid,
  output logic [VIM_VEC_W-1:0]      o_core_vec_addr,
  // software dispatch view
  output logic [VIM_IDX_W-1:0]      o_irq_index,
  output logic [VIM_VEC_W-1:0]      o_irq_vector,
  // parity status
  output logic                      o_par_err,
  output logic                      o_par_sticky
);

  if (NCH != 128) begin : g_chk
    $error("vim_top: channel count must be 128");
  end

  // default source for each channel; numbering makes it the identity,
  // listed by group so the reset table reads as the channel plan
  function automatic logic [VIM_IDX_W-1:0] dflt_src(input int ch);
    logic [VIM_IDX_W-1:0] c;
    c = VIM_IDX_W'(ch);
    dflt_src = c;
    unique case (c)
      SRC_ERR_HIGH, SRC_ERR_LOW:
        dflt_src = c;
      SRC_TICK_CMP0, 7'h03, 7'h04, SRC_TICK_CMP3:
        dflt_src = c;
      SRC_TICK_OVF0, SRC_TICK_OVF1, SRC_TICK_BASE:
        dflt_src = c;
      SRC_CONV1_EVT, SRC_CONV1_G1, SRC_CONV1_G2:
        dflt_src = c;
      SRC_CONV2_EVT, SRC_CONV2_G1, SRC_CONV2_G2:
        dflt_src = c;
      SRC_CONV1_MAG, SRC_CONV2_MAG:
        dflt_src = c;
      SRC_PT1_L0, SRC_PT1_L1, SRC_TU1_L0, SRC_TU1_L1:
        dflt_src = c;
      SRC_PT2_L0, SRC_PT2_L1, SRC_TU2_L0, SRC_TU2_L1:
        dflt_src = c;
      SRC_CAN1_L0, SRC_CAN1_L1, SRC_CAN1_IF3:
        dflt_src = c;
      SRC_CAN2_L0, SRC_CAN2_L1, SRC_CAN2_IF3:
        dflt_src = c;
      SRC_CAN3_L0, SRC_CAN3_L1, SRC_CAN3_IF3:
        dflt_src = c;
      SRC_BSPI1_L0, SRC_BSPI1_L1, SRC_PLAIN_SPI_TWO_L0, SRC_PLAIN_SPI_TWO_L1:
        dflt_src = c;
      SRC_BSPI3_L0, SRC_BSPI3_L1, SRC_BSPI5_L0, SRC_BSPI5_L1,
      SRC_PLAIN_SPI_FOUR_L0, SRC_PLAIN_SPI_FOUR_L1:
        dflt_src = c;
      SRC_SER_L0, SRC_SER_L1, SRC_I2C_L0:
        dflt_src = c;
      SRC_LIN_L0, SRC_LIN_L1:
        dflt_src = c;
      // gpio, crc, dma, flash and the rest keep their own number too
      default:
        dflt_src = c;
    endcase
  endfunction

  // table slot for a channel: slot 0 belongs to the phantom handler
  function automatic logic [VIM_IDX_W-1:0] slot_of(input logic [VIM_IDX_W-1:0] ch);
    slot_of = VIM_IDX_W'(ch + 7'h01);
  endfunction

  logic [VIM_IDX_W-1:0] map_reg [NCH];
  logic [NCH-1:0]       en_reg;
  logic [NCH-1:0]       src_live;
  logic [NCH-1:0]       chan_req;
  logic [NCH-1:0]       pend;
  logic                 win_valid;
  logic [VIM_IDX_W-1:0] win_idx;
  logic [VIM_IDX_W-1:0] rd_slot;
  logic                 stg_valid_reg;
  logic [VIM_IDX_W-1:0] stg_index_reg;
  logic [VIM_VEC_W-1:0] tbl_data;
  logic                 tbl_err;
  logic [VIM_VEC_W-1:0] vec_sel;

  // source map: loaded from the constant plan on reset, then software owned
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int ch = 0; ch < NCH; ch++) begin
        map_reg[ch] <= dflt_src(ch);
      end
    end else if (i_map_wr) begin
      map_reg[i_map_chan] <= i_map_src;
    end
  end

  // per-channel enables
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      en_reg <= VIM_EN_RST;
    end else if (i_en_wr) begin
      en_reg[i_en_chan] <= i_en_val;
    end
  end

  // reserved source numbers carry no peripheral; force them low
  assign src_live = i_src_req & ~VIM_RSVD_MASK;

  // route each channel to its mapped source; remapping is also how a
  // source is given a different priority, since priority is position
  always_comb begin
    chan_req = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      chan_req[ch] = src_live[map_reg[ch]];
    end
  end

  // only enabled channels that own a table slot can compete
  assign pend = chan_req & en_reg & VIM_USE_MASK;

  vim_prio_enc #(
    .N  (NCH),
    .IW (VIM_IDX_W)
  ) u_prio (
    .i_req   (pend),
    .o_valid (win_valid),
    .o_idx   (win_idx)
  );

  // look up the winner's slot, or the phantom slot when nothing pends
  assign rd_slot = win_valid ? slot_of(win_idx) : VIM_PHANTOM;

  vim_vec_table #(
    .DEPTH (NCH),
    .AW    (VIM_IDX_W),
    .W     (VIM_VEC_W)
  ) u_table (
    .i_mclk     (i_mclk),
    .i_wr       (i_vt_wr),
    .i_waddr    (i_vt_addr),
    .i_wdata    (i_vt_data),
    .i_par_flip (i_vt_par_flip),
    .i_raddr    (rd_slot),
    .o_rdata    (tbl_data),
    .o_par_err  (tbl_err)
  );

  // first stage: hold the winner so it lines up with the table read
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      stg_valid_reg <= 1'b0;
      stg_index_reg <= VIM_PHANTOM;
    end else begin
      stg_valid_reg <= win_valid;
      stg_index_reg <= rd_slot;
    end
  end

  // a corrupt word is never handed out; the fallback routine runs instead
  assign vec_sel = tbl_err ? FALLBACK_VEC : tbl_data;

  // second stage: software view of index and vector, always maintained
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_irq_index  <= VIM_PHANTOM;
      o_irq_vector <= VIM_VEC_RST;
    end else begin
      o_irq_index  <= stg_index_reg;
      o_irq_vector <= vec_sel;
    end
  end

  // hardware vector port; the address is only qualified when the port
  // is in use, so a core on software dispatch sees a plain request
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_core_irq       <= 1'b0;
      o_core_vec_valid <= 1'b0;
      o_core_vec_addr  <= VIM_VEC_RST;
    end else begin
      o_core_irq       <= stg_valid_reg;
      o_core_vec_valid <= stg_valid_reg & i_vec_port_en;
      o_core_vec_addr  <= vec_sel;
    end
  end

  // parity status: live level plus a sticky flag; a new error wins
  // over a clear in the same cycle so no event is lost
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_par_err    <= 1'b0;
      o_par_sticky <= 1'b0;
    end else begin
      o_par_err <= tbl_err;
      if (tbl_err) begin
        o_par_sticky <= 1'b1;
      end else if (i_par_clr) begin
        o_par_sticky <= 1'b0;
      end
    end
  end

endmodule // vim_top

/* File: sim/vim_core_model.sv */
`timescale 1ns/100ps
// core side of the vector port: jumps straight to the offered address
module vim_core_model (
  input  wire logic        i_mclk,
  input  wire logic        i_use_port,
  input  wire logic        i_vec_valid,
  input  wire logic [31:0] i_vec_addr,
  output logic             o_port_en,
  output logic [31:0]      o_taken
);
  // port use only changes on an edge, as a real core would
  always_ff @(posedge i_mclk) o_port_en <= i_use_port;
  // no software lookup: the address is taken as offered
  always_ff @(posedge i_mclk) if (i_vec_valid) o_taken <= i_vec_addr;
endmodule // vim_core_model

/* File: sim/vim_checker.sv */
`timescale 1ns/100ps
// relations between request inputs and dispatch outputs
module vim_checker
  import vim_pkg::*;
#(
  parameter int          NCH          = VIM_NCH,
  parameter logic [31:0] FALLBACK_VEC = 32'h0
) (
  input wire logic                 i_mclk,
  input wire logic                 i_srst,
  input wire logic [NCH-1:0]       i_src_req,
  input wire logic                 i_vec_port_en,
  input wire logic                 i_par_clr,
  input wire logic                 o_core_irq,
  input wire logic                 o_core_vec_valid,
  input wire logic [VIM_VEC_W-1:0] o_core_vec_addr,
  input wire logic [VIM_IDX_W-1:0] o_irq_index,
  input wire logic [VIM_VEC_W-1:0] o_irq_vector,
  input wire logic                 o_par_err,
  input wire logic                 o_par_sticky
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // reserved inputs are dead, so only real sources two edges back count
  chk_rsvd_quiet: assert property (
    $past(i_src_req & ~VIM_RSVD_MASK, 2) == '0 |-> !o_core_irq)
    else $error("core irq without any live source");
  chk_index_irq: assert property (
    (o_irq_index != '0) == o_core_irq)
    else $error("index and core irq disagree");
  chk_vec_mirror: assert property (
    o_irq_vector == o_core_vec_addr)
    else $error("software vector differs from port vector");
  chk_port_gate: assert property (
    o_core_vec_valid == (o_core_irq && $past(i_vec_port_en)))
    else $error("vector valid not gated by port use");
  chk_par_fallback: assert property (
    o_par_err |-> o_core_vec_addr == FALLBACK_VEC)
    else $error("corrupt word reached the core");
  chk_sticky_set: assert property (
    $rose(o_par_sticky) |-> o_par_err)
    else $error("sticky flag set without parity error");
  chk_sticky_hold: assert property (
    o_par_sticky && !i_par_clr |=> o_par_sticky)
    else $error("sticky flag lost without clear");
  chk_sticky_clr: assert property (
    o_par_sticky && i_par_clr |=> o_par_sticky == o_par_err)
    else $error("sticky clear mishandled");
  cover property (o_core_vec_valid);
  cover property (o_par_err);
  cover property (o_core_irq && o_irq_index == 7'h04);
endmodule // vim_checker

bind vim_top vim_checker #(.NCH(NCH), .FALLBACK_VEC(FALLBACK_VEC)) i_vim_checker (.*);

/* File: sim/vectored_interrupt_manager_tb_top.sv */
`timescale 1ns/100ps
module vectored_interrupt_manager_tb_top;
  import vim_pkg::*;
  localparam logic [31:0] FB = 32'h0bad_f00d;
  logic i_mclk, i_srst, i_en_wr, i_en_val, i_map_wr, i_vt_wr, i_vt_par_flip;
  logic i_par_clr, use_port, vec_port_en, o_core_irq, o_core_vec_valid;
  logic o_par_err, o_par_sticky;
  logic [127:0] i_src_req;
  logic [6:0]   i_en_chan, i_map_chan, i_map_src, i_vt_addr, o_irq_index;
  logic [31:0]  i_vt_data, o_core_vec_addr, o_irq_vector, taken;
  int           errors, checks_done, cyc;
  // default channels in source groups, in dflt_src order, one line per t_map run
  int dch[49] = '{0, 20, 2, 3, 4, 5, 6, 7, 8, 14, 15, 28, 50, 51, 57, 31, 59,
                  10, 24, 11, 25, 63, 73, 65, 75, 16, 29, 44, 35, 42, 46, 45, 55, 60,
                  12, 26, 17, 30, 37, 38, 53, 56, 49, 54, 64, 74, 66, 13, 27};

  vim_top #(.FALLBACK_VEC(FB)) i_vim_top (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_src_req(i_src_req),
    .i_en_wr(i_en_wr), .i_en_chan(i_en_chan), .i_en_val(i_en_val),
    .i_map_wr(i_map_wr), .i_map_chan(i_map_chan), .i_map_src(i_map_src),
    .i_vt_wr(i_vt_wr), .i_vt_addr(i_vt_addr), .i_vt_data(i_vt_data),
    .i_vt_par_flip(i_vt_par_flip), .i_vec_port_en(vec_port_en), .i_par_clr(i_par_clr),
    .o_core_irq(o_core_irq), .o_core_vec_valid(o_core_vec_valid),
    .o_core_vec_addr(o_core_vec_addr), .o_irq_index(o_irq_index),
    .o_irq_vector(o_irq_vector), .o_par_err(o_par_err), .o_par_sticky(o_par_sticky));
  vim_core_model i_vim_core_model (.i_mclk(i_mclk), .i_use_port(use_port),
    .i_vec_valid(o_core_vec_valid), .i_vec_addr(o_core_vec_addr),
    .o_port_en(vec_port_en), .o_taken(taken));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // a hung run is cut short at 8000 cycles, well after the expected run of under a thousand cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      results;
    end
  end

  function automatic logic [31:0] vw(input int k);
    return 32'h8000_0100 + k;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobes are raised one cycle and dropped after the taking edge; an idle
  // edge follows so a back-to-back call never re-raises in the same step
  task automatic en(input logic [6:0] ch, input logic v);
    i_en_wr = 1'b1;
    i_en_chan = ch;
    i_en_val = v;
    step(1);
    i_en_wr = 1'b0;
    step(1);
  endtask
  task automatic map(input logic [6:0] ch, input logic [6:0] src);
    i_map_wr = 1'b1;
    i_map_chan = ch;
    i_map_src = src;
    step(1);
    i_map_wr = 1'b0;
    step(1);
  endtask
  task automatic vt(input logic [6:0] a, input logic [31:0] d, input logic f);
    i_vt_wr = 1'b1;
    i_vt_addr = a;
    i_vt_data = d;
    i_vt_par_flip = f;
    step(1);
    i_vt_wr = 1'b0;
    step(1);
  endtask
  // raise a request pattern, judge the winner, then let it drain
  task automatic pend(input logic [127:0] m, input logic [6:0] idx);
    i_src_req = m;
    step(3);
    cmp(o_irq_index, idx);
    cmp(o_irq_vector, vw(idx));
    cmp(o_core_irq, idx != 7'h00);
    i_src_req = '0;
    step(3);
  endtask

  task automatic t_defaults;
    cmp(o_core_irq, 1'b0);
    cmp(o_irq_index, 7'h00);
    cmp(o_core_vec_addr, 32'h0);
    for (int a = 0; a < 128; a++) vt(a[6:0], vw(a), 1'b0);
    pend(128'h0, 7'h00);
    pend(128'h1, 7'h01);
    pend(128'h1 << 20, 7'h00);
  endtask
  task automatic t_map(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      en(dch[i][6:0], 1'b1);
      pend(128'h1 << dch[i], 7'(dch[i] + 1));
      en(dch[i][6:0], 1'b0);
    end
  endtask
  task automatic t_prio;
    en(7'h05, 1'b1);
    en(7'h03, 1'b1);
    pend((128'h1 << 5) | (128'h1 << 3), 7'h04);
    en(7'h6f, 1'b1);
    pend(128'h1 << 111, 7'h70);
    map(7'h7f, 7'h6f);
    en(7'h6f, 1'b0);
    en(7'h7f, 1'b1);
    pend(128'h1 << 111, 7'h00);
    en(7'h7f, 1'b0);
    en(7'h05, 1'b0);
  endtask
  task automatic t_remap;
    pend(128'h1, 7'h00);
    en(7'h01, 1'b1);
    pend(128'h2, 7'h00);
    map(7'h01, 7'h14);
    pend(128'h1 << 20, 7'h02);
    en(7'h01, 1'b0);
  endtask
  task automatic t_port;
    use_port = 1'b1;
    i_src_req = 128'h8;
    step(4);
    cmp(o_core_vec_valid, 1'b1);
    cmp(taken, vw(4));
    use_port = 1'b0;
    step(3);
    cmp(o_core_vec_valid, 1'b0);
    cmp(o_irq_vector, vw(4));
    i_src_req = '0;
    step(3);
  endtask
  task automatic t_parity;
    vt(7'h04, vw(4), 1'b1);
    i_src_req = 128'h8;
    step(3);
    cmp({o_par_err, o_par_sticky}, 2'b11);
    cmp(o_core_vec_addr, FB);
    i_src_req = '0;
    step(3);
    cmp({o_par_err, o_par_sticky}, 2'b01);
    i_par_clr = 1'b1;
    step(1);
    i_par_clr = 1'b0;
    step(1);
    cmp(o_par_sticky, 1'b0);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {i_en_wr, i_en_val, i_map_wr, i_vt_wr, i_vt_par_flip, i_par_clr, use_port} = '0;
    {i_en_chan, i_map_chan, i_map_src, i_vt_addr, i_vt_data, i_src_req} = '0;
    i_srst = 1'b1;
    step(10);
    // the table has no reset; load the phantom slot while reset holds so
    // the idle read after release shows a defined word
    vt(7'h00, vw(0), 1'b0);
    step(8);
    i_srst = 1'b0;
    t_defaults;
    t_map(0, 16);
    t_map(17, 33);
    t_map(34, 48);
    t_prio;
    t_remap;
    t_port;
    t_parity;
    results;
  end
endmodule // vectored_interrupt_manager_tb_top
